// File: hdl/ida_top.sv
// Purpose: Indirect data addressing unit with two pointer pairs.
// Assumes: Register port at ref_clk_in; read data one cycle later.
// Notes:   addr_in[8] low is direct bank access, high is register space.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.

// ---------------------------------------------------------------
// Module
// ---------------------------------------------------------------
// Functional notes
// - Indirect addresses are windows into data memory
// - Plain access keeps the pointer unchanged
// - Post-increment uses pointer, then adds one
// - Post-decrement uses pointer, then subtracts one
// - Pre-increment adds one, then accesses
// - Pointer high part has four bits only
// - Pointer low part is full eight bits
// - Bank select four bits, resets to zero
// - Absent registers and bits read as zero
module ida_top
   import ida_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [DATA_W-1:0] rd_data_out,
   output logic [3:0] bank_select_out
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Pointer plus signed byte offset, twelve-bit wrap
   function automatic logic [PTR_W-1:0] ptr_offset(
      input logic [PTR_W-1:0] ptr,
      input logic [DATA_W-1:0] ofs);
      ptr_offset = ptr + {{4{ofs[7]}}, ofs};
   endfunction

   // Pointer stepped by one up or down, twelve-bit wrap
   function automatic logic [PTR_W-1:0] ptr_step(
      input logic [PTR_W-1:0] ptr,
      input logic up);
      ptr_step = up ? ptr + 12'h001 : ptr - 12'h001;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // Pointer pairs: high part in [11:8], low part in [7:0]
   logic [PTR_W-1:0] ptr_r [2];
   logic [PTR_W-1:0] ptr_nxt [2];
   // Bank select for direct access
   logic [3:0] bank_r;
   logic [3:0] bank_nxt;
   // Arithmetic flags, five bits
   logic [4:0] flags_r;
   logic [4:0] flags_nxt;
   // Interrupt control two, masked bits only
   logic [7:0] ictl2_r;
   logic [7:0] ictl2_nxt;
   // Working register, source of the offset
   logic [DATA_W-1:0] wreg_r;
   logic [DATA_W-1:0] wreg_nxt;

   // ------------------------------------------------------------
   // Decode signals
   // ------------------------------------------------------------
   logic acc; // Any access this cycle
   logic sfr; // Register space selected
   logic [7:0] ofs; // Offset within the space
   logic [PTR_W-1:0] mem_addr; // Data memory address
   logic mem_we; // Data memory write
   logic alt_en; // Read returns register data
   logic [DATA_W-1:0] alt_data; // Register data for a read
   logic [PTR_W-1:0] cur; // Pointer of the selected pair

   assign acc = wr_in | rd_in;
   assign sfr = addr_in[ADDR_W-1];
   assign ofs = addr_in[7:0];

   // ------------------------------------------------------------
   // Next-state and access decode
   // ------------------------------------------------------------
   // Compute register updates and the memory access
   always_comb
   begin
      ptr_nxt = ptr_r;
      bank_nxt = bank_r;
      flags_nxt = flags_r;
      ictl2_nxt = ictl2_r;
      wreg_nxt = wreg_r;
      mem_addr = {bank_r, ofs};
      mem_we = 1'b0;
      alt_en = 1'b1;
      alt_data = '0; // Unmapped reads zero
      cur = '0;
      if (!sfr)
      begin
         // Direct access in the bank window
         alt_en = 1'b0;
         mem_we = wr_in;
      end
      else
      begin
         for (int p = 0; p < 2; p++)
         begin
            if (ofs[7:3] == (p == 0 ? PAIR1_BASE[7:3] : PAIR2_BASE[7:3]))
            begin
               cur = ptr_r[p];
               case (ofs[2:0])
                  SUB_HIGH:
                  begin
                     // Upper nibble reads zero
                     alt_data = {4'h0, cur[PTR_W-1:PTR_HIGH_LSB]};
                     if (wr_in)
                     begin
                        ptr_nxt[p][PTR_W-1:PTR_HIGH_LSB] =
                           wr_data_in[HIGH_W-1:0];
                     end
                  end
                  SUB_LOW:
                  begin
                     // Full byte
                     alt_data = cur[7:0];
                     if (wr_in)
                     begin
                        ptr_nxt[p][7:0] = wr_data_in;
                     end
                  end
                  SUB_PLAIN:
                  begin
                     // Window at pointer, pointer kept
                     mem_addr = cur;
                     alt_en = 1'b0;
                     mem_we = wr_in;
                  end
                  SUB_POSTINC:
                  begin
                     // Access at pointer, then step up
                     mem_addr = cur;
                     alt_en = 1'b0;
                     mem_we = wr_in;
                     if (acc)
                     begin
                        ptr_nxt[p] = ptr_step(cur, 1'b1);
                     end
                  end
                  SUB_POSTDEC:
                  begin
                     // Access at pointer, then step down
                     mem_addr = cur;
                     alt_en = 1'b0;
                     mem_we = wr_in;
                     if (acc)
                     begin
                        ptr_nxt[p] = ptr_step(cur, 1'b0);
                     end
                  end
                  SUB_PREINC:
                  begin
                     // Step up first, access the new value
                     mem_addr = ptr_step(cur, 1'b1);
                     alt_en = 1'b0;
                     mem_we = wr_in;
                     if (acc)
                     begin
                        ptr_nxt[p] = ptr_step(cur, 1'b1);
                     end
                  end
                  SUB_OFFSET:
                  begin
                     // Pointer plus working register, kept
                     mem_addr = ptr_offset(cur, wreg_r);
                     alt_en = 1'b0;
                     mem_we = wr_in;
                  end
                  default:
                  begin
                     alt_data = '0; // Hole reads zero
                  end
               endcase
            end
         end
         case (ofs)
            BANK_OFS:
            begin
               alt_data = {4'h0, bank_r};
               if (wr_in)
               begin
                  bank_nxt = wr_data_in[3:0];
               end
            end
            FLAGS_OFS:
            begin
               alt_data = {3'h0, flags_r};
               if (wr_in)
               begin
                  flags_nxt = wr_data_in[4:0];
               end
            end
            ICTL2_OFS:
            begin
               // Unimplemented bits read zero
               alt_data = ictl2_r & ICTL2_MASK;
               if (wr_in)
               begin
                  ictl2_nxt = wr_data_in & ICTL2_MASK;
               end
            end
            WREG_OFS:
            begin
               alt_data = wreg_r;
               if (wr_in)
               begin
                  wreg_nxt = wr_data_in;
               end
            end
            default:
            begin
               alt_en = alt_en;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Register all state; pointers start at zero
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         ptr_r[0] <= PTR_RST;
         ptr_r[1] <= PTR_RST;
         bank_r <= BANK_RST;
         flags_r <= FLAGS_RST;
         ictl2_r <= ICTL2_RST;
         wreg_r <= WREG_RST;
      end
      else
      begin
         ptr_r <= ptr_nxt;
         bank_r <= bank_nxt;
         flags_r <= flags_nxt;
         ictl2_r <= ictl2_nxt;
         wreg_r <= wreg_nxt;
      end
   end

   assign bank_select_out = bank_r;

   // ------------------------------------------------------------
   // Data memory
   // ------------------------------------------------------------
   // Read data register sits inside the memory
   ida_data_mem u_mem (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .we_in(mem_we),
      .re_in(rd_in),
      .addr_in(mem_addr),
      .wdata_in(wr_data_in),
      .alt_en_in(alt_en),
      .alt_data_in(alt_data),
      .rdata_out(rd_data_out)
   );

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Access to a window of pair one
   sequence s_hit1(logic [2:0] sub);
      acc && sfr && ofs == (PAIR1_BASE | {5'h00, sub});
   endsequence

   // Indirect write through the plain window of pair one
   sequence s_ind_wr;
      wr_in && sfr && ofs == (PAIR1_BASE | {5'h00, SUB_PLAIN});
   endsequence

   a_window_addr: assert property (
      s_hit1(SUB_PLAIN) |-> mem_addr == ptr_r[0] && !alt_en)
      else $error("plain window not at pointer");
   a_plain_keep: assert property (
      s_hit1(SUB_PLAIN) |=> ptr_r[0] == $past(ptr_r[0]))
      else $error("plain access moved pointer");

   a_postinc_step: assert property (
      s_hit1(SUB_POSTINC) |-> mem_addr == ptr_r[0]
      ##1 ptr_r[0] == $past(ptr_r[0]) + 12'h001)
      else $error("post-increment wrong");
   a_postdec_step: assert property (
      s_hit1(SUB_POSTDEC) |-> mem_addr == ptr_r[0]
      ##1 ptr_r[0] == $past(ptr_r[0]) - 12'h001)
      else $error("post-decrement wrong");

   a_preinc_addr: assert property (
      s_hit1(SUB_PREINC) |-> mem_addr == ptr_r[0] + 12'h001
      ##1 ptr_r[0] == $past(mem_addr))
      else $error("pre-increment wrong");
   a_offset_addr: assert property (
      s_hit1(SUB_OFFSET) |-> mem_addr ==
      ptr_r[0] + {{4{wreg_r[7]}}, wreg_r} ##1 $stable(ptr_r[0]))
      else $error("offset access wrong");

   a_high_width: assert property (
      rd_in && sfr && ofs == PAIR2_BASE |=> rd_data_out[7:4] == 4'h0)
      else $error("pointer high upper bits not zero");
   a_low_readback: assert property (
      s_hit1(SUB_LOW) ##0 wr_in ##1 rd_in && sfr && ofs == PAIR1_BASE + 8'h01
      |=> rd_data_out == $past(wr_data_in, 2))
      else $error("pointer low readback wrong");

   a_bank_reset: assert property (
      $rose(rst_n_in) |-> bank_select_out == BANK_RST)
      else $error("bank select not zero after reset");
   a_unmapped_zero: assert property (
      rd_in && sfr && ofs > WREG_OFS |=> rd_data_out == 8'h00)
      else $error("unmapped read not zero");

   a_step_wrap: assert property (
      s_hit1(SUB_POSTINC) ##0 ptr_r[0] == 12'hfff |=> ptr_r[0] == 12'h000)
      else $error("pointer did not wrap");
   a_window_data: assert property (
      s_ind_wr ##1 rd_in && !sfr && {bank_r, ofs} == $past(ptr_r[0])
      |=> rd_data_out == $past(wr_data_in, 2))
      else $error("window write not in memory");

endmodule

// File: hdl/ida_pkg.sv
// Purpose: Shared constants for the indirect data addressing unit.
// Assumes: Single 250 MHz clock, synchronous active-low reset.
// Notes:   Offsets are special-register offsets on the register port.

// ---------------------------------------------------------------
// Package
// ---------------------------------------------------------------
package ida_pkg;

   // Widths of the data path and the data memory
   localparam int DATA_W = 8;
   localparam int PTR_W = 12;
   localparam int MEM_DEPTH = 4096;
   localparam int ADDR_W = 9;

   // Pointer pair windows: base offset of each pair
   localparam logic [7:0] PAIR1_BASE = 8'h00;
   localparam logic [7:0] PAIR2_BASE = 8'h08;

   // Sub-offsets inside one pair window
   localparam logic [2:0] SUB_HIGH = 3'h0;
   localparam logic [2:0] SUB_LOW = 3'h1;
   localparam logic [2:0] SUB_PLAIN = 3'h2;
   localparam logic [2:0] SUB_POSTINC = 3'h3;
   localparam logic [2:0] SUB_POSTDEC = 3'h4;
   localparam logic [2:0] SUB_PREINC = 3'h5;
   localparam logic [2:0] SUB_OFFSET = 3'h6;

   // Other special registers
   localparam logic [7:0] BANK_OFS = 8'h10;
   localparam logic [7:0] FLAGS_OFS = 8'h11;
   localparam logic [7:0] ICTL2_OFS = 8'h12;
   localparam logic [7:0] WREG_OFS = 8'h13;

   // Reset values and implemented-bit masks
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [7:0] ICTL2_RST = 8'hf5;
   localparam logic [7:0] ICTL2_MASK = 8'hf5;
   localparam logic [7:0] WREG_RST = 8'h00;

   // Field positions of the pointer pair
   localparam int PTR_HIGH_LSB = 8;
   localparam int HIGH_W = 4;

endpackage

// File: hdl/ida_data_mem.sv
// Purpose: Data memory of the addressing unit with a registered read.
// Assumes: One access per cycle; read and write never together.
// Notes:   The read register can load a bypass value for register reads.

// ---------------------------------------------------------------
// Module
// ---------------------------------------------------------------
module ida_data_mem
   import ida_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic we_in,
   input wire logic re_in,
   input wire logic [PTR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic alt_en_in,
   input wire logic [DATA_W-1:0] alt_data_in,
   output logic [DATA_W-1:0] rdata_out
);

   // Storage array
   logic [DATA_W-1:0] mem_r [MEM_DEPTH];
   // Read register and its next value
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Choose bypass data or the memory byte on a read
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (re_in)
      begin
         rdata_nxt = alt_en_in ? alt_data_in : mem_r[addr_in];
      end
   end

   // Register the read data
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // Memory writes, no reset on the array
   always_ff @(posedge ref_clk_in)
   begin
      if (we_in)
      begin
         mem_r[addr_in] <= wdata_in;
      end
   end

   assign rdata_out = rdata_r;

endmodule

// File: bench/ida_tb.sv
// Purpose: Self-checking bench for the indirect data addressing unit.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   A bench model of memory, pointers and working register.

module testbench
   import ida_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Signals and bench model
   // ------------------------------------------------------------
   logic ref_clk_in = 1'b0; // 250 MHz clock
   logic rst_n_in = 1'b0; // Active-low reset
   logic [8:0] addr_in = 9'h000;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rd_data_out;
   logic [3:0] bank_select_out;
   logic [7:0] mem_m [0:4095]; // Expected memory contents
   logic [11:0] ptr_m [0:1]; // Expected pointer pairs
   logic [7:0] wreg_m; // Expected working register
   logic [2:0] modes [0:4];
   integer seed = 87;
   int check_count = 0;
   int err_total = 0;

   ida_top i_ida_top (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .addr_in(addr_in),
      .wr_data_in(wr_data_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rd_data_out(rd_data_out),
      .bank_select_out(bank_select_out)
   );

   // Clock: invert every half period
   always #2 ref_clk_in = ~ref_clk_in;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task automatic rd_val(input logic [8:0] a, output logic [7:0] v);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1;
      v = rd_data_out;
   endtask

   // Register-space address of a pair sub-offset
   function automatic logic [8:0] pa(input int p, input logic [2:0] s);
      return {1'b1, (p != 0 ? PAIR2_BASE : PAIR1_BASE) + {5'h00, s}};
   endfunction

   // Data address used by an access mode
   function automatic logic [11:0] eff(input logic [11:0] p,
      input logic [2:0] m, input logic [7:0] w);
      if (m == SUB_PREINC) return p + 12'h001;
      if (m == SUB_OFFSET) return p + {{4{w[7]}}, w};
      return p;
   endfunction

   // Pointer value after an access mode
   function automatic logic [11:0] nxt(input logic [11:0] p,
      input logic [2:0] m);
      if (m == SUB_POSTINC || m == SUB_PREINC) return p + 12'h001;
      if (m == SUB_POSTDEC) return p - 12'h001;
      return p;
   endfunction

   // Access through a window and update the model
   task automatic acc(input int p, input logic [2:0] m, input bit w,
      input logic [7:0] d);
      logic [11:0] e;
      logic [7:0] v;
      e = eff(ptr_m[p], m, wreg_m);
      if (w)
      begin
         wr_reg(pa(p, m), d);
         mem_m[e] = d;
      end
      else
      begin
         rd_val(pa(p, m), v);
         chk(v, mem_m[e]);
      end
      ptr_m[p] = nxt(ptr_m[p], m);
   endtask

   task automatic set_ptr(input int p, input logic [11:0] v);
      wr_reg(pa(p, SUB_HIGH), {4'h0, v[11:8]});
      wr_reg(pa(p, SUB_LOW), v[7:0]);
      ptr_m[p] = v;
   endtask

   task automatic chk_ptr(input int p);
      logic [7:0] v;
      rd_val(pa(p, SUB_HIGH), v);
      chk(v, {4'h0, ptr_m[p][11:8]});
      rd_val(pa(p, SUB_LOW), v);
      chk(v, ptr_m[p][7:0]);
   endtask

   task automatic set_w(input logic [7:0] v);
      wr_reg({1'b1, WREG_OFS}, v);
      wreg_m = v;
   endtask

   // Write strobe, then read strobe in the very next cycle, no gap
   task automatic wr_rd2(input logic [8:0] wa, input logic [7:0] d,
      input logic [8:0] ra, output logic [7:0] v);
      @(posedge ref_clk_in);
      addr_in <= wa;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      addr_in <= ra;
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1;
      v = rd_data_out;
   endtask

   // Write then read back a register, back to back
   task automatic wr_rd(input logic [8:0] a, input logic [7:0] d,
      output logic [7:0] v);
      wr_rd2(a, d, a, v);
   endtask

   // Counts and verdict, then end of run
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Cut a hang short
   initial
   begin
      repeat (100000) @(posedge ref_clk_in);
      err_total++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [7:0] v;
      logic [7:0] a;
      logic [3:0] b;
      int p;
      modes = '{SUB_PLAIN, SUB_POSTINC, SUB_POSTDEC, SUB_PREINC, SUB_OFFSET};
      ptr_m[0] = PTR_RST;
      ptr_m[1] = PTR_RST;
      wreg_m = WREG_RST;
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1;
      // Reset values and implemented bits
      chk({4'h0, bank_select_out}, 8'h00);
      rd_val({1'b1, BANK_OFS}, v);
      chk(v, 8'h00);
      chk_ptr(0);
      chk_ptr(1);
      wr_rd({1'b1, BANK_OFS}, 8'hff, v);
      chk(v, 8'h0f);
      chk({4'h0, bank_select_out}, 8'h0f);
      wr_rd(pa(1, SUB_HIGH), 8'hff, v);
      chk(v, 8'h0f);
      ptr_m[1] = 12'hf00;
      wr_rd({1'b1, FLAGS_OFS}, 8'hff, v);
      chk(v, 8'h1f);
      rd_val({1'b1, ICTL2_OFS}, v);
      chk(v, 8'hf5);
      wr_rd({1'b1, ICTL2_OFS}, 8'h0a, v);
      chk(v, 8'h00);
      wr_rd(pa(0, SUB_LOW), 8'ha7, v);
      chk(v, 8'ha7);
      ptr_m[0][7:0] = 8'ha7;
      foreach (modes[i])
      begin
         a = (i == 0) ? 8'h07 : (i == 1) ? 8'h0f : 8'h14 + 8'(i * 40);
         wr_rd({1'b1, a}, 8'hff, v);
         chk(v, 8'h00);
      end
      $display("test registers done");
      // Fill memory through post-increment, pointer wraps to zero
      set_ptr(0, 12'h000);
      for (int i = 0; i < 4096; i++)
         acc(0, SUB_POSTINC, 1'b1, 8'($random(seed)));
      chk_ptr(0);
      $display("test fill done");
      // Direct bank reads land on the same memory
      repeat (8)
      begin
         b = 4'($random(seed));
         a = 8'($random(seed));
         wr_reg({1'b1, BANK_OFS}, {4'h0, b});
         rd_val({1'b0, a}, v);
         chk(v, mem_m[{b, a}]);
      end
      // Window write, then direct read of the same byte at once
      wr_reg({1'b1, BANK_OFS}, 8'h03);
      set_ptr(0, 12'h3c5);
      wr_rd2(pa(0, SUB_PLAIN), 8'h69, {1'b0, 8'hc5}, v);
      mem_m[12'h3c5] = 8'h69;
      chk(v, mem_m[12'h3c5]);
      $display("test direct done");
      // Reset in mid-run: registers back to reset values, memory kept
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1;
      ptr_m[0] = PTR_RST;
      ptr_m[1] = PTR_RST;
      wreg_m = WREG_RST;
      chk({4'h0, bank_select_out}, {4'h0, BANK_RST});
      chk_ptr(0);
      chk_ptr(1);
      $display("test reset done");
      // Wrap corners of each mode
      set_ptr(1, 12'hfff);
      acc(1, SUB_POSTINC, 1'b0, 8'h00);
      chk_ptr(1);
      set_ptr(0, 12'h000);
      acc(0, SUB_POSTDEC, 1'b0, 8'h00);
      chk_ptr(0);
      set_ptr(1, 12'hfff);
      acc(1, SUB_PREINC, 1'b1, 8'h5a);
      acc(1, SUB_PLAIN, 1'b0, 8'h00);
      set_w(8'h80);
      set_ptr(0, 12'h010);
      acc(0, SUB_OFFSET, 1'b0, 8'h00);
      set_w(8'h7f);
      set_ptr(1, 12'hfff);
      acc(1, SUB_OFFSET, 1'b1, 8'ha5);
      acc(1, SUB_OFFSET, 1'b0, 8'h00);
      chk_ptr(0);
      chk_ptr(1);
      $display("test corners done");
      // Random traffic over both pairs and all modes
      for (int i = 0; i < 400; i++)
      begin
         p = $unsigned($random(seed)) % 2;
         if ($unsigned($random(seed)) % 8 == 0)
            set_w(8'($random(seed)));
         if ($unsigned($random(seed)) % 8 == 0)
            set_ptr(p, 12'($random(seed)));
         acc(p, modes[$unsigned($random(seed)) % 5], 1'($random(seed)),
            8'($random(seed)));
      end
      chk_ptr(0);
      chk_ptr(1);
      $display("test random done");
      print_verdict();
   end

endmodule
